// >>> shared/rcb_pkg.sv
package rcb_pkg;

  // Core clock rate
  localparam int CLK_HZ        = 100_000_000;
  localparam int CLK_MHZ       = 100;

  // Long power-button press
  localparam int BTN_HOLD_MS   = 5000;
  localparam int BTN_HOLD_CYC  = BTN_HOLD_MS * (CLK_HZ / 1000);

  // Monitor UART
  localparam int UART_BPS      = 115200;
  localparam logic [15:0] UART_DIV = 16'(CLK_HZ / UART_BPS);
  localparam int MON_DELAY_US  = 10;
  localparam int MON_DELAY_CYC = MON_DELAY_US * CLK_MHZ;
  localparam int MON_CNT_W     = 10;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_PLL   = 8'h04;
  localparam logic [7:0] OFF_VREG  = 8'h08;
  localparam logic [7:0] OFF_BOOT  = 8'h0c;
  localparam logic [7:0] OFF_STAT  = 8'h10;
  localparam logic [7:0] OFF_CAUSE = 8'h14;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register fields
  localparam int CTRL_W         = 4;
  localparam int CTRL_BTN_EN    = 0;
  localparam int CTRL_CLK_RTC   = 1;
  localparam int CTRL_ETH       = 2;
  localparam int CTRL_SUSPEND   = 3;
  localparam logic [3:0] CTRL_RESET = 4'h1;

  // PLL factor = 1.0 + code * 0.5
  localparam int PLL_W = 4;
  localparam logic [3:0] PLL_RESET = 4'h0;
  localparam logic [3:0] PLL_MAX   = 4'he;
  localparam logic [3:0] PLL_USB   = 4'h8;

  // Regulator codes: core [3:0], io [7:4], analog [11:8]
  localparam int VREG_W = 12;
  localparam logic [11:0] VREG_RESET = 12'h888;

  localparam int BOOT_FOUND_BIT = 0;
  localparam int BOOT_DONE_BIT  = 1;

  // Cause bits: core supply, pin, watchdog, debugger, button
  localparam int CAUSE_W = 5;

  typedef enum logic [2:0] {
    STG_WAIT,
    STG_SPI,
    STG_NAND,
    STG_SD,
    STG_ROM,
    STG_USER
  } rcb_stage_e;

endpackage

// >>> shared/rcb_boot_if.sv
interface rcb_boot_if;
  import rcb_pkg::*;

  logic       spiPin;
  logic       nandPin;
  logic       ioPin;
  logic       swDone;
  logic       swFound;
  rcb_stage_e stage;
  logic       uartMon;
  logic       io3v3;
  logic       spiSeen;
  logic       nandSeen;

  modport seq (
    input  spiPin, nandPin, ioPin, swDone, swFound,
    output stage, uartMon, io3v3, spiSeen, nandSeen
  );

  modport ctl (
    output spiPin, nandPin, ioPin, swDone, swFound,
    input  stage, uartMon, io3v3, spiSeen, nandSeen
  );

endinterface

// >>> hw/rcb_reset_merge.sv
module rcb_reset_merge #(
  parameter int unsigned HOLD_CYCLES = rcb_pkg::BTN_HOLD_CYC
) (
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  input  wire logic                       extResetN,
  input  wire logic                       powerButton,
  input  wire logic                       coreSupplyOk,
  input  wire logic                       wdogReset,
  input  wire logic                       dbgReset,
  input  wire logic                       btnEnable,
  output logic                            sysResetN,
  output logic                            extLow,
  output logic [rcb_pkg::CAUSE_W-1:0]     srcEvents
);
  import rcb_pkg::*;

  logic [2:0]  pinMeta;
  logic [2:0]  pinSync;
  logic [31:0] holdCnt;
  logic [31:0] next_holdCnt;
  logic        fired;
  logic        next_fired;
  logic        btnFire;
  logic        next_btnFire;
  logic        rawN;
  logic        rstMeta;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pinMeta <= 3'h5;
      pinSync <= 3'h5;
    end
    else
    begin
      pinMeta <= {coreSupplyOk, powerButton, extResetN};
      pinSync <= pinMeta;
    end
  end

  // One reset per press: the counter waits for release before re-arming
  always_comb
  begin
    next_holdCnt = holdCnt;
    next_fired   = fired;
    next_btnFire = 1'b0;
    if (!pinSync[1])
    begin
      next_holdCnt = 32'h0;
      next_fired   = 1'b0;
    end
    else if (!fired)
    begin
      next_holdCnt = holdCnt + 32'h1;
      if (holdCnt == 32'(HOLD_CYCLES - 1))
      begin
        next_fired   = 1'b1;
        next_btnFire = btnEnable;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      holdCnt <= 32'h0;
      fired   <= 1'b0;
      btnFire <= 1'b0;
    end
    else
    begin
      holdCnt <= next_holdCnt;
      fired   <= next_fired;
      btnFire <= next_btnFire;
    end
  end

  // Any source pulls the raw reset; the pin is active low
  assign rawN = resetn & extResetN & coreSupplyOk & ~wdogReset & ~dbgReset & ~btnFire;

  // Assert at once, release on a clock edge
  always_ff @(posedge clk_sys or negedge rawN)
  begin
    if (!rawN)
    begin
      rstMeta   <= 1'b0;
      sysResetN <= 1'b0;
    end
    else
    begin
      rstMeta   <= 1'b1;
      sysResetN <= rstMeta;
    end
  end

  assign extLow    = ~pinSync[0];
  assign srcEvents = {btnFire, dbgReset, wdogReset, ~pinSync[0], ~pinSync[2]};

endmodule

// >>> hw/rcb_boot_seq.sv
module rcb_boot_seq (
  input  wire logic clk_sys,
  input  wire logic rstN,
  rcb_boot_if.seq   bif
);
  import rcb_pkg::*;

  rcb_stage_e           stage;
  rcb_stage_e           next_stage;
  logic [MON_CNT_W-1:0] dly;
  logic [MON_CNT_W-1:0] next_dly;
  logic                 uartMon;
  logic                 next_uartMon;
  logic                 io3v3;
  logic                 next_io3v3;
  logic                 spiSeen;
  logic                 next_spiSeen;
  logic                 nandSeen;
  logic                 next_nandSeen;

  always_comb
  begin
    next_stage    = stage;
    next_dly      = dly;
    next_uartMon  = uartMon;
    next_io3v3    = io3v3;
    next_spiSeen  = spiSeen;
    next_nandSeen = nandSeen;
    case (stage)
      STG_WAIT:
        if (dly == MON_CNT_W'(MON_DELAY_CYC - 1))
        begin
          next_uartMon = 1'b1;
          next_io3v3   = bif.ioPin;
          next_spiSeen = bif.spiPin;
          if (bif.spiPin)
            next_stage = STG_SPI;
          else
          begin
            next_nandSeen = bif.nandPin;
            next_stage    = bif.nandPin ? STG_NAND : STG_SD;
          end
        end
        else
          next_dly = dly + MON_CNT_W'(1);
      STG_SPI:
        if (bif.swDone)
        begin
          if (bif.swFound)
            next_stage = STG_USER;
          else
          begin
            next_nandSeen = bif.nandPin;
            next_stage    = bif.nandPin ? STG_NAND : STG_SD;
          end
        end
      STG_NAND:
        if (bif.swDone)
          next_stage = bif.swFound ? STG_USER : STG_SD;
      STG_SD:
        if (bif.swDone)
          next_stage = bif.swFound ? STG_USER : STG_ROM;
      default:
        next_stage = stage;
    endcase
  end

  // Any merged reset lands here, so the whole order starts over
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      stage    <= STG_WAIT;
      dly      <= '0;
      uartMon  <= 1'b0;
      io3v3    <= 1'b0;
      spiSeen  <= 1'b0;
      nandSeen <= 1'b0;
    end
    else
    begin
      stage    <= next_stage;
      dly      <= next_dly;
      uartMon  <= next_uartMon;
      io3v3    <= next_io3v3;
      spiSeen  <= next_spiSeen;
      nandSeen <= next_nandSeen;
    end
  end

  assign bif.stage    = stage;
  assign bif.uartMon  = uartMon;
  assign bif.io3v3    = io3v3;
  assign bif.spiSeen  = spiSeen;
  assign bif.nandSeen = nandSeen;

endmodule

// >>> hw/rcb_reset_clock_boot.sv
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
module rcb_reset_clock_boot #(
  parameter int unsigned BTN_HOLD_CYCLES = rcb_pkg::BTN_HOLD_CYC
) (
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  input  wire logic [7:0]               awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [7:0]               araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  input  wire logic                     extResetN,
  input  wire logic                     powerButton,
  input  wire logic                     coreSupplyOk,
  input  wire logic                     wdogReset,
  input  wire logic                     dbgReset,
  input  wire logic                     usbVbusDetect,
  input  wire logic                     ioLevelStrap,
  input  wire logic                     usbClassStrap,
  input  wire logic                     serialBootCsStrap,
  input  wire logic                     nandChipEnable,
  output logic                          sysResetN,
  output logic                          clkBufEn,
  output logic                          digitalPowerdown,
  output logic                          clkSelRtc,
  output logic                          mainOscPowerdown,
  output logic [rcb_pkg::PLL_W-1:0]     pllMultCode,
  output logic [rcb_pkg::VREG_W-1:0]    vregCodes,
  output logic                          ioLevel3v3,
  output logic                          usbAudioClass,
  output logic                          uartMonitorEn,
  output logic [15:0]                   uartBaudDiv,
  output logic [2:0]                    bootStage
);
  import rcb_pkg::*;

  localparam int PIN_VBUS = 0;
  localparam int PIN_UCLS = 1;
  localparam int PIN_IO   = 2;
  localparam int PIN_SPI  = 3;
  localparam int PIN_NAND = 4;

  function automatic logic [31:0] strbMask(input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      strbMask[i*8 +: 8] = {8{s[i]}};
  endfunction

  rcb_boot_if bif ();

  logic                extLow;
  logic [CAUSE_W-1:0]  srcEv;
  logic [4:0]          pinMeta;
  logic [4:0]          pinSync;
  logic                rstInt;

  logic                awHave, next_awHave;
  logic [7:0]          awAddrQ, next_awAddrQ;
  logic                wHave, next_wHave;
  logic [31:0]         wDataQ, next_wDataQ;
  logic [3:0]          wStrbQ, next_wStrbQ;
  logic                next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]          next_bresp, next_rresp;
  logic [31:0]         next_rdata;
  logic [CAUSE_W-1:0]  cause, next_cause;
  logic                next_clkBufEn, next_digitalPowerdown;

  logic [CTRL_W-1:0]   ctrl, next_ctrl;
  logic [PLL_W-1:0]    pllReg, next_pllReg;
  logic [VREG_W-1:0]   next_vregCodes;
  logic                bootDone, next_bootDone;
  logic                bootFound, next_bootFound;
  logic                next_clkSelRtc, next_mainOscPowerdown;
  logic [PLL_W-1:0]    next_pllMultCode;
  logic                next_usbAudioClass;
  logic                usbConnD, next_usbConnD;

  logic                doWrite;
  logic [31:0]         wm;
  logic [31:0]         rdWord;
  logic                rdOk;
  logic [CAUSE_W-1:0]  causeClr;
  logic [PLL_W-1:0]    pllWr;
  logic                usbOn;

  rcb_reset_merge #(
    .HOLD_CYCLES (BTN_HOLD_CYCLES)
  ) uReset (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .extResetN    (extResetN),
    .powerButton  (powerButton),
    .coreSupplyOk (coreSupplyOk),
    .wdogReset    (wdogReset),
    .dbgReset     (dbgReset),
    .btnEnable    (ctrl[CTRL_BTN_EN]),
    .sysResetN    (rstInt),
    .extLow       (extLow),
    .srcEvents    (srcEv)
  );

  rcb_boot_seq uBoot (
    .clk_sys (clk_sys),
    .rstN    (rstInt),
    .bif     (bif)
  );

  assign sysResetN     = rstInt;
  assign bif.spiPin    = pinSync[PIN_SPI];
  assign bif.nandPin   = pinSync[PIN_NAND];
  assign bif.ioPin     = pinSync[PIN_IO];
  assign bif.swDone    = bootDone;
  assign bif.swFound   = bootFound;
  assign ioLevel3v3    = bif.io3v3;
  assign uartMonitorEn = bif.uartMon;
  assign bootStage     = bif.stage;

  // Straps and detect lines are asynchronous to the core clock
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pinMeta <= 5'h0;
      pinSync <= 5'h0;
    end
    else
    begin
      pinMeta <= {nandChipEnable, serialBootCsStrap, ioLevelStrap, usbClassStrap, usbVbusDetect};
      pinSync <= pinMeta;
    end
  end

  always_comb
  begin
    next_awHave  = awHave;
    next_awAddrQ = awAddrQ;
    next_wHave   = wHave;
    next_wDataQ  = wDataQ;
    next_wStrbQ  = wStrbQ;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_ctrl    = ctrl;
    next_pllReg  = pllReg;
    next_vregCodes = vregCodes;
    next_bootDone  = 1'b0;
    next_bootFound = bootFound;
    causeClr     = '0;
    doWrite      = awHave && wHave && !bvalid;
    wm           = strbMask(wStrbQ);
    pllWr        = (pllReg & ~wm[PLL_W-1:0]) | (wDataQ[PLL_W-1:0] & wm[PLL_W-1:0]);

    if (awvalid && awready)
    begin
      next_awHave  = 1'b1;
      next_awAddrQ = {awaddr[7:2], 2'b00};
    end
    if (wvalid && wready)
    begin
      next_wHave  = 1'b1;
      next_wDataQ = wdata;
      next_wStrbQ = wstrb;
    end
    if (doWrite)
    begin
      next_awHave = 1'b0;
      next_wHave  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = RESP_OKAY;
      if (awAddrQ == OFF_CTRL)
        next_ctrl = (ctrl & ~wm[CTRL_W-1:0]) | (wDataQ[CTRL_W-1:0] & wm[CTRL_W-1:0]);
      else if (awAddrQ == OFF_PLL)
        next_pllReg = (pllWr > PLL_MAX) ? PLL_MAX : pllWr;
      else if (awAddrQ == OFF_VREG)
        next_vregCodes = (vregCodes & ~wm[VREG_W-1:0]) | (wDataQ[VREG_W-1:0] & wm[VREG_W-1:0]);
      else if (awAddrQ == OFF_BOOT)
      begin
        next_bootDone  = wDataQ[BOOT_DONE_BIT] & wm[BOOT_DONE_BIT];
        if (wm[BOOT_FOUND_BIT])
          next_bootFound = wDataQ[BOOT_FOUND_BIT];
      end
      else if (awAddrQ == OFF_CAUSE)
        causeClr = wDataQ[CAUSE_W-1:0] & wm[CAUSE_W-1:0];
      else if (awAddrQ != OFF_STAT)
        next_bresp = RESP_SLVERR;
    end
    if (bvalid && bready)
      next_bvalid = 1'b0;
    next_awready = !next_awHave && !next_bvalid;
    next_wready  = !next_wHave && !next_bvalid;

    rdOk = 1'b1;
    if (araddr[7:2] == OFF_CTRL[7:2])
      rdWord = {{(32-CTRL_W){1'b0}}, ctrl};
    else if (araddr[7:2] == OFF_PLL[7:2])
      rdWord = {{(32-PLL_W){1'b0}}, pllMultCode};
    else if (araddr[7:2] == OFF_VREG[7:2])
      rdWord = {{(32-VREG_W){1'b0}}, vregCodes};
    else if (araddr[7:2] == OFF_BOOT[7:2])
      rdWord = {31'h0, bootFound};
    else if (araddr[7:2] == OFF_STAT[7:2])
      rdWord = {23'h0, pinSync[PIN_VBUS], bif.nandSeen, bif.spiSeen, usbAudioClass,
                bif.io3v3, bif.uartMon, bif.stage};
    else if (araddr[7:2] == OFF_CAUSE[7:2])
      rdWord = {{(32-CAUSE_W){1'b0}}, cause};
    else
    begin
      rdWord = 32'h0;
      rdOk   = 1'b0;
    end
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rdata  = rdWord;
      next_rresp  = rdOk ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && rready)
      next_rvalid = 1'b0;
    next_arready = !next_rvalid;

    // A source still active while its bit is cleared keeps the bit set
    next_cause = (cause & ~causeClr) | srcEv;

    next_clkBufEn         = !extLow;
    next_digitalPowerdown = extLow;

    // Ethernet and USB both need 60 MHz from a 12 MHz input
    usbOn                 = pinSync[PIN_VBUS];
    next_mainOscPowerdown = ctrl[CTRL_SUSPEND];
    next_clkSelRtc        = ctrl[CTRL_SUSPEND] ||
                            (ctrl[CTRL_CLK_RTC] && !usbOn && !ctrl[CTRL_ETH]);
    next_pllMultCode      = (usbOn || ctrl[CTRL_ETH]) ? PLL_USB : pllReg;

    next_usbConnD      = usbOn;
    next_usbAudioClass = (usbOn && !usbConnD) ? pinSync[PIN_UCLS] : usbAudioClass;
  end

  // Bus and cause flags survive internal resets so software can read why
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      awHave  <= 1'b0;
      awAddrQ <= 8'h0;
      wHave   <= 1'b0;
      wDataQ  <= 32'h0;
      wStrbQ  <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
      cause   <= '0;
      clkBufEn         <= 1'b0;
      digitalPowerdown <= 1'b1;
    end
    else
    begin
      awHave  <= next_awHave;
      awAddrQ <= next_awAddrQ;
      wHave   <= next_wHave;
      wDataQ  <= next_wDataQ;
      wStrbQ  <= next_wStrbQ;
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      cause   <= next_cause;
      clkBufEn         <= next_clkBufEn;
      digitalPowerdown <= next_digitalPowerdown;
    end
  end

  // Every merged reset returns control, clocks and regulator codes to defaults
  always_ff @(posedge clk_sys or negedge rstInt)
  begin
    if (!rstInt)
    begin
      ctrl             <= CTRL_RESET;
      pllReg           <= PLL_RESET;
      vregCodes        <= VREG_RESET;
      bootDone         <= 1'b0;
      bootFound        <= 1'b0;
      clkSelRtc        <= 1'b0;
      mainOscPowerdown <= 1'b0;
      pllMultCode      <= PLL_RESET;
      usbAudioClass    <= 1'b0;
      usbConnD         <= 1'b0;
      uartBaudDiv      <= UART_DIV;
    end
    else
    begin
      ctrl             <= next_ctrl;
      pllReg           <= next_pllReg;
      vregCodes        <= next_vregCodes;
      bootDone         <= next_bootDone;
      bootFound        <= next_bootFound;
      clkSelRtc        <= next_clkSelRtc;
      mainOscPowerdown <= next_mainOscPowerdown;
      pllMultCode      <= next_pllMultCode;
      usbAudioClass    <= next_usbAudioClass;
      usbConnD         <= next_usbConnD;
      uartBaudDiv      <= UART_DIV;
    end
  end

endmodule

// >>> tb/rcb_pins.sv
module rcb_pins (
  input  wire logic       pinHold,
  input  wire logic       btnPress,
  input  wire logic [3:0] straps,
  output logic            extResetN,
  output logic            powerButton,
  output logic            ioLevelStrap,
  output logic            usbClassStrap,
  output logic            serialBootCsStrap,
  output logic            nandChipEnable
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pulled-up pin, low only while held
  assign extResetN = !pinHold;
  assign powerButton = btnPress;
  // Resistor straps never float
  assign ioLevelStrap = straps[0];
  assign usbClassStrap = straps[1];
  assign serialBootCsStrap = straps[2];
  assign nandChipEnable = straps[3];
endmodule

// >>> tb/rcb_props.sv
module rcb_props (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        extResetN,
  input wire logic        coreSupplyOk,
  input wire logic        usbVbusDetect,
  input wire logic        sysResetN,
  input wire logic        clkBufEn,
  input wire logic        digitalPowerdown,
  input wire logic        clkSelRtc,
  input wire logic        mainOscPowerdown,
  input wire logic [3:0]  pllMultCode,
  input wire logic [11:0] vregCodes,
  input wire logic        uartMonitorEn,
  input wire logic [2:0]  bootStage
);
  timeunit 1ns;
  timeprecision 1ns;
  import rcb_pkg::*;
  logic [10:0] waitCnt, next_waitCnt;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  sequence seqBothTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  // Saturates so a stuck sequencer cannot wrap back into range
  always_comb
  begin
    next_waitCnt = waitCnt;
    if (!sysResetN)
      next_waitCnt = 11'h0;
    else if (bootStage == 3'h0 && waitCnt != 11'h7ff)
      next_waitCnt = waitCnt + 11'h1;
  end
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      waitCnt <= 11'h0;
    else
      waitCnt <= next_waitCnt;
  a_pin_buf_off: assert property (!extResetN [*6] |-> !clkBufEn && digitalPowerdown)
    else $error("buffer on");
  a_src_reset: assert property (!extResetN || !coreSupplyOk |-> !sysResetN)
    else $error("no reset");
  // Quiet sources two samples before the rise show the release waited on the clock
  a_sync_release: assert property ($rose(sysResetN) |->
    $past(extResetN, 2) && $past(coreSupplyOk, 2)) else $error("early release");
  a_reset_dflt: assert property (!sysResetN [*2] |-> vregCodes == VREG_RESET
    && bootStage == 3'h0) else $error("defaults");
  a_pll_usb: assert property ((usbVbusDetect && sysResetN) [*5] |-> pllMultCode == PLL_USB)
    else $error("pll usb");
  a_osc_rtc: assert property (mainOscPowerdown |-> clkSelRtc)
    else $error("osc off");
  a_mon_delay: assert property ($rose(uartMonitorEn) |-> waitCnt inside {[995:1005]})
    else $error("monitor delay");
  a_write_resp: assert property (seqBothTaken |-> ##2 bvalid)
    else $error("no bvalid");
endmodule
bind rcb_reset_clock_boot rcb_props rcb_props_i (.*);

// >>> tb/rcb_reset_clock_boot_bench.sv
module rcb_reset_clock_boot_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import rcb_pkg::*;
  logic        clk_sys = 1'b0, resetn = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rng = 32'h8f11, rd, rdata;
  logic [3:0]  wstrb = 4'h0, straps = 4'h0, pllMultCode;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        usbVbusDetect = 0, pinHold = 0, btnPress = 0, resetSeen = 0;
  logic [2:0]  src = 3'h0, bootStage;
  wire logic   coreSupplyOk = !src[0];
  wire logic   wdogReset = src[1];
  wire logic   dbgReset = src[2];
  logic        awready, wready, bvalid, arready, rvalid, sysResetN, clkBufEn;
  logic        digitalPowerdown, clkSelRtc, mainOscPowerdown, ioLevel3v3;
  logic        usbAudioClass, uartMonitorEn, extResetN, powerButton;
  logic        ioLevelStrap, usbClassStrap, serialBootCsStrap, nandChipEnable;
  logic [1:0]  bresp, rresp, resp;
  logic [11:0] vregCodes;
  logic [15:0] uartBaudDiv;
  int          numErrors = 0, checked = 0;
  // Short hold keeps the long-press run small
  rcb_reset_clock_boot #(.BTN_HOLD_CYCLES(50)) rcb_reset_clock_boot_i (.*);
  rcb_pins rcb_pins_i (.*);
  initial forever #5 clk_sys = ~clk_sys;
  always @(negedge sysResetN) resetSeen = 1'b1;
  task automatic tally_and_finish();
    if (numErrors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      numErrors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic lim(int n, int m);
    if (n >= m)
    begin
      chk("wait", 0, 1);
      tally_and_finish();
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s);
    int n = 0;
    cyc(1);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      cyc(1);
      n++;
      if (awready)
        awvalid <= 0;
      if (wready)
        wvalid <= 0;
    end while (bvalid !== 1'b1 && n < 200);
    bready <= 0;
    resp = bresp;
    lim(n, 200);
  endtask
  task automatic rdr(logic [7:0] a);
    int n = 0;
    cyc(1);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      cyc(1);
      n++;
      if (arready)
        arvalid <= 0;
    end while (rvalid !== 1'b1 && n < 200);
    rready <= 0;
    rd = rdata;
    resp = rresp;
    lim(n, 200);
  endtask
  function automatic logic [2:0] nxt(logic [2:0] s, logic nandOn);
    if (s == 3'h1 && nandOn)
      return 3'h2;
    return (s == 3'h3) ? 3'h4 : 3'h3;
  endfunction
  task automatic boot(logic [3:0] st, logic hit);
    int n = 0;
    logic [2:0] s;
    straps <= st;
    pinHold <= 1;
    cyc(6);
    chk("bufEn", 0, clkBufEn);
    chk("pdown", 1, digitalPowerdown);
    chk("sysRst", 0, sysResetN);
    chk("io", 0, ioLevel3v3);
    pinHold <= 0;
    s = st[2] ? 3'h1 : nxt(3'h1, st[3]);
    while (bootStage === 3'h0 && n < 1200)
    begin
      cyc(1);
      n++;
    end
    lim(n, 1200);
    straps <= st ^ 4'h1;
    while (s inside {3'h1, 3'h2, 3'h3})
    begin
      rdr(OFF_STAT);
      chk("stage", s, rd[2:0]);
      wr(OFF_BOOT, {30'h0, 1'b1, hit}, 4'h1);
      s = hit ? 3'h5 : nxt(s, st[3]);
    end
    rdr(OFF_STAT);
    chk("stage", s, rd[2:0]);
    chk("io", st[0], ioLevel3v3);
    chk("mon", 1, uartMonitorEn);
  endtask
  initial
  begin
    #500_000;
    chk("timeout", 0, 1);
    tally_and_finish();
  end
  initial
  begin
    logic [31:0] v;
    logic [11:0] w;
    cyc(8);
    resetn <= 1;
    chk("baud", 100_000_000 / 115200, uartBaudDiv);
    rdr(OFF_CTRL);
    chk("ctrl", 1, rd);
    rdr(8'h20);
    chk("unmapped", RESP_SLVERR, resp);
    wr(8'h20, 32'h0, 4'hf);
    chk("bresp", RESP_SLVERR, resp);
    for (int c = 0; c < 16; c++)
    begin
      wr(OFF_PLL, c, 4'h1);
      chk("bresp", RESP_OKAY, resp);
      rdr(OFF_PLL);
      chk("pll", (c > 14) ? 14 : c, rd);
    end
    wr(OFF_CTRL, 32'h5, 4'h1);
    rdr(OFF_PLL);
    chk("pll", 8, rd);
    wr(OFF_CTRL, 32'h9, 4'h1);
    cyc(2);
    chk("rtc", 1, clkSelRtc);
    chk("osc", 1, mainOscPowerdown);
    wr(OFF_CTRL, 32'h3, 4'h1);
    cyc(2);
    chk("rtc", 1, clkSelRtc);
    chk("osc", 0, mainOscPowerdown);
    wr(OFF_CTRL, 32'h7, 4'h1);
    cyc(2);
    chk("rtc", 0, clkSelRtc);
    wr(OFF_CTRL, 32'h1, 4'h1);
    // Audio class first, then mass storage on a fresh connection
    for (int u = 1; u >= 0; u--)
    begin
      straps <= 4'(u << 1);
      cyc(3);
      usbVbusDetect <= 1;
      cyc(5);
      chk("class", u, usbAudioClass);
      rdr(OFF_PLL);
      chk("pll", 8, rd);
      usbVbusDetect <= 0;
    end
    v = xs();
    w = {{4{v[9]}}, {8{v[8]}}};
    wr(OFF_VREG, xs(), v[11:8]);
    rdr(OFF_VREG);
    chk("vreg", (rng[11:0] & w) | (12'h888 & ~w), rd);
    for (int i = 0; i < 3; i++)
    begin
      src <= 3'(1 << i);
      cyc(3);
      chk("src", 0, sysResetN);
      src <= 3'h0;
      cyc(3);
      rdr(OFF_CAUSE);
      chk("cause", 1, rd[(i == 0) ? 0 : i + 1]);
      wr(OFF_CAUSE, 32'h1f, 4'h1);
    end
    rdr(OFF_CAUSE);
    chk("cause", 0, rd);
    rdr(OFF_VREG);
    chk("vreg", 32'h888, rd);
    wr(OFF_CTRL, 32'h0, 4'h1);
    for (int e = 0; e < 2; e++)
    begin
      resetSeen <= 0;
      btnPress <= 1;
      cyc(70);
      btnPress <= 0;
      chk("button", e, resetSeen);
      wr(OFF_CTRL, 32'h1, 4'h1);
    end
    boot(4'b1101, 1'b0);
    boot(4'b1000, 1'b0);
    boot(4'b0000, 1'b1);
    tally_and_finish();
  end
endmodule
